// ===== src/pwm_dead_time_insertion.sv
// Compare timing, dead-time insertion and trigger events for three PWM pairs
// Notes on behaviour
// (RULE_01) Dead-time only in motor modes
// (RULE_02) Insert dead-time when either side turns active
// (RULE_03) Slow prescale: length times four clocks
// (RULE_04) Fast prescale: length times sixteen clocks
// (RULE_05) Duty match masks output, starts counter
// (RULE_06) Counter reaching length removes the mask
// (RULE_07) Two-channel symmetric mode: no dead-time
// (RULE_08) Long dead-time swallows the high pulse
// (RULE_09) Long dead-time swallows the low pulse
// (RULE_10) Full duty: high held on, no dead-time
// (RULE_11) Zero duty: low held on, no dead-time
// (RULE_12) Symmetric: compare on both count directions
// (RULE_13) Asymmetric: high duty compared counting up
// (RULE_14) Asymmetric: low duty compared counting down
// (RULE_15) Six trigger compares pulse ADC starts
// (RULE_16) Every timing event offers an interrupt request
// (RULE_17) Motor selected by clear mode bit; style codes
// (RULE_18) One-channel modes: low is inverted high
// (RULE_19) Each match restarts the dead-time counter
`timescale 1ns/1ns
module pwm_dead_time_insertion #(
	parameter int CW = pwm_dt_pkg::CNT_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	// Prescaled PWM clock, one pulse per PWM clock
	input wire logic pwm_clk_en,
	// Period counter from the base timer
	input wire logic [CW-1:0] period_count,
	input wire logic count_up,
	input wire logic [CW-1:0] period_value,
	// Duty values per channel
	input wire logic [pwm_dt_pkg::N_CH-1:0][CW-1:0] duty_hi,
	input wire logic [pwm_dt_pkg::N_CH-1:0][CW-1:0] duty_lo,
	// Mode and dead-time settings
	input wire pwm_dt_pkg::dt_cfg_t dt_cfg,
	// Trigger compare values and modes
	input wire logic [pwm_dt_pkg::N_TRIG-1:0][CW-1:0] trig_value,
	input wire logic [pwm_dt_pkg::N_TRIG-1:0][1:0] trig_mode,
	// Gate driver outputs
	output logic [pwm_dt_pkg::N_CH-1:0] gate_hi,
	output logic [pwm_dt_pkg::N_CH-1:0] gate_lo,
	// Dead-time interval running, per pair
	output logic [pwm_dt_pkg::N_CH-1:0] dt_busy,
	// ADC start pulses
	output logic [pwm_dt_pkg::N_TRIG-1:0] adc_trigger,
	// Event pulses toward the interrupt controller
	output pwm_dt_pkg::events_t irq_events
);
	// Whole state of the block apart from the dead-time pairs
	typedef struct packed {
		logic [pwm_dt_pkg::N_CH-1:0] hi_lvl;
		logic [pwm_dt_pkg::N_CH-1:0] lo_lvl;
		logic [pwm_dt_pkg::N_TRIG-1:0] trig;
		pwm_dt_pkg::events_t evt;
	} top_state_t;

	top_state_t s_r; // Registered state
	top_state_t s_nxt; // Next state

	// Mode decodes
	logic motor_mode; // Motor PWM selected
	logic one_ch; // One-channel motor styles
	logic sym_style; // Symmetric one-channel style
	logic [pwm_dt_pkg::DT_CNT_W-1:0] dt_target; // Interval in PWM clocks

	// Per-channel helpers
	logic [pwm_dt_pkg::N_CH-1:0] full_duty; // Duty equals period
	logic [pwm_dt_pkg::N_CH-1:0] zero_duty; // Duty is zero
	logic [pwm_dt_pkg::N_CH-1:0] dt_on; // Insertion active
	logic [pwm_dt_pkg::N_CH-1:0] raw_lo; // Low level before masking

	// Interval length in PWM clocks from length and prescale
	function automatic logic [pwm_dt_pkg::DT_CNT_W-1:0] dt_clocks(
		input logic [pwm_dt_pkg::DT_LEN_W-1:0] len,
		input logic fast
	);
		logic [pwm_dt_pkg::DT_CNT_W-1:0] w;
		// Widen first so the shift cannot drop bits
		w = {4'h0, len};
		if (fast) begin
			dt_clocks = w << pwm_dt_pkg::DT_SHIFT_FAST; // RULE_04
		end else begin
			dt_clocks = w << pwm_dt_pkg::DT_SHIFT_SLOW; // RULE_03
		end
	endfunction

	// Compare hit in the wanted count direction on a PWM clock
	function automatic logic dir_hit(
		input logic [CW-1:0] cnt,
		input logic [CW-1:0] val,
		input logic en,
		input logic up,
		input logic want_up,
		input logic want_down
	);
		dir_hit = en && cnt == val && ((up && want_up) || (!up && want_down));
	endfunction

	// Mode decode from the select bit and style code
	// Style code 11 falls back to the two-channel decode
	assign motor_mode = !dt_cfg.normal_mode_select; // RULE_17
	assign sym_style = dt_cfg.motor_channel_style == pwm_dt_pkg::STYLE_ONE_SYM;
	assign one_ch = motor_mode && (sym_style ||
		dt_cfg.motor_channel_style == pwm_dt_pkg::STYLE_ONE_ASYM); // RULE_17
	assign dt_target = dt_clocks(dt_cfg.dead_time_length, dt_cfg.dead_time_prescale_select);

	// Per-channel insertion enable and low-side source
	always_comb begin
		for (int i = 0; i < pwm_dt_pkg::N_CH; i++) begin
			// Duty at the period or at zero pins one side
			full_duty[i] = duty_hi[i] == period_value;
			zero_duty[i] = duty_hi[i] == '0;
			// Only one-channel motor styles, never at full or zero duty
			dt_on[i] = dt_cfg.dead_time_enable && one_ch
				&& !full_duty[i] && !zero_duty[i]; // RULE_01 RULE_07 RULE_10 RULE_11
			// Low side is the inverse of high in one-channel styles
			raw_lo[i] = one_ch ? ~s_r.hi_lvl[i] : s_r.lo_lvl[i]; // RULE_18
		end
	end

	// Raw waveform, triggers and events
	always_comb begin
		s_nxt = s_r;
		// Trigger and event pulses last one cycle
		s_nxt.trig = '0;
		s_nxt.evt = '0;
		// Start of each period
		s_nxt.evt.period_start = pwm_clk_en && count_up && period_count == '0; // RULE_16
		for (int i = 0; i < pwm_dt_pkg::N_CH; i++) begin
			if (!motor_mode) begin
				// Independent channels: level while counter below duty
				if (pwm_clk_en) begin
					s_nxt.hi_lvl[i] = period_count < duty_hi[i];
					s_nxt.lo_lvl[i] = period_count < duty_lo[i];
				end
			end else if (!one_ch) begin
				// Two-channel symmetric: each side from its own duty
				if (dir_hit(period_count, duty_hi[i], pwm_clk_en, count_up, 1'b1, 1'b0)) begin
					s_nxt.hi_lvl[i] = 1'b1; // RULE_07 RULE_12
				end else if (dir_hit(period_count, duty_hi[i], pwm_clk_en, count_up, 1'b0, 1'b1)) begin
					s_nxt.hi_lvl[i] = 1'b0;
				end
				// Low side from its own duty value
				if (dir_hit(period_count, duty_lo[i], pwm_clk_en, count_up, 1'b1, 1'b0)) begin
					s_nxt.lo_lvl[i] = 1'b1;
				end else if (dir_hit(period_count, duty_lo[i], pwm_clk_en, count_up, 1'b0, 1'b1)) begin
					s_nxt.lo_lvl[i] = 1'b0;
				end
			end else if (full_duty[i]) begin
				// Full duty: high side on for the whole period
				if (pwm_clk_en) begin
					s_nxt.hi_lvl[i] = 1'b1; // RULE_10
				end
			end else if (zero_duty[i]) begin
				// Zero duty: high off, inverted low stays on
				if (pwm_clk_en) begin
					s_nxt.hi_lvl[i] = 1'b0; // RULE_11
				end
			end else if (sym_style) begin
				// Symmetric: high duty in both directions
				if (dir_hit(period_count, duty_hi[i], pwm_clk_en, count_up, 1'b1, 1'b0)) begin
					s_nxt.hi_lvl[i] = 1'b1; // RULE_12
				end else if (dir_hit(period_count, duty_hi[i], pwm_clk_en, count_up, 1'b0, 1'b1)) begin
					s_nxt.hi_lvl[i] = 1'b0; // RULE_12
				end
			end else begin
				// Asymmetric: high duty up, low duty down
				if (dir_hit(period_count, duty_hi[i], pwm_clk_en, count_up, 1'b1, 1'b0)) begin
					s_nxt.hi_lvl[i] = 1'b1; // RULE_13
				end else if (dir_hit(period_count, duty_lo[i], pwm_clk_en, count_up, 1'b0, 1'b1)) begin
					s_nxt.hi_lvl[i] = 1'b0; // RULE_14
				end
			end
			// Any level change is a duty-match event
			s_nxt.evt.duty_match[i] = (s_nxt.hi_lvl[i] != s_r.hi_lvl[i])
				|| (s_nxt.lo_lvl[i] != s_r.lo_lvl[i]); // RULE_16
		end
		// Trigger compares by direction mode
		for (int t = 0; t < pwm_dt_pkg::N_TRIG; t++) begin
			s_nxt.trig[t] = dir_hit(period_count, trig_value[t], pwm_clk_en, count_up,
				trig_mode[t][0], trig_mode[t][1]); // RULE_15
			s_nxt.evt.trigger[t] = s_nxt.trig[t]; // RULE_16
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Raw levels start inactive
			s_r.hi_lvl <= {pwm_dt_pkg::N_CH{pwm_dt_pkg::RST_LEVEL}};
			s_r.lo_lvl <= {pwm_dt_pkg::N_CH{pwm_dt_pkg::RST_LEVEL}};
			// No pulse pending after reset
			s_r.trig <= '0;
			s_r.evt <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// One dead-time unit per pair
	// All pairs share one interval length
	for (genvar g = 0; g < pwm_dt_pkg::N_CH; g++) begin : g_pair
		dead_time_pair u_dead_time_pair (
			.clk_sys(clk_sys),
			.rst(rst),
			.pwm_clk_en(pwm_clk_en),
			.dt_on(dt_on[g]),
			.dt_target(dt_target),
			.raw_hi(s_r.hi_lvl[g]),
			.raw_lo(raw_lo[g]),
			.out_hi(gate_hi[g]),
			.out_lo(gate_lo[g]),
			.dt_busy(dt_busy[g])
		);
	end

	// Registered pulses out
	assign adc_trigger = s_r.trig;
	assign irq_events = s_r.evt;

	// Checks run on the system clock and rest during reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Slow prescale gives four clocks per step
	property p_slow_scale;
		!dt_cfg.dead_time_prescale_select |->
			dt_target == {2'h0, dt_cfg.dead_time_length, 2'h0};
	endproperty
	a_slow_scale: assert property (p_slow_scale) else $error("slow dead-time scale wrong"); // RULE_03

	// Fast prescale gives sixteen clocks per step
	property p_fast_scale;
		dt_cfg.dead_time_prescale_select |->
			dt_target == {dt_cfg.dead_time_length, 4'h0};
	endproperty
	a_fast_scale: assert property (p_fast_scale) else $error("fast dead-time scale wrong"); // RULE_04

	// Two-channel symmetric and normal modes never insert
	property p_no_dt_modes;
		(!motor_mode || dt_cfg.motor_channel_style == pwm_dt_pkg::STYLE_TWO_SYM) |-> dt_on == '0;
	endproperty
	a_no_dt_modes: assert property (p_no_dt_modes) else $error("dead-time in wrong mode"); // RULE_07

	// One-channel styles drive low as inverse of high
	property p_inverse;
		one_ch |-> raw_lo == ~s_r.hi_lvl;
	endproperty
	a_inverse: assert property (p_inverse) else $error("low side not inverse"); // RULE_18

	// Full duty forces high on, then the pin shows it
	sequence s_full;
		one_ch && full_duty[0] && pwm_clk_en;
	endsequence
	property p_full;
		s_full |=> s_r.hi_lvl[0] ##1 (gate_hi[0] || !one_ch || !full_duty[0]);
	endproperty
	a_full: assert property (p_full) else $error("full duty not held high"); // RULE_10

	// Zero duty forces high off and low on
	property p_zero;
		one_ch && zero_duty[0] && pwm_clk_en |=> !s_r.hi_lvl[0] && raw_lo[0];
	endproperty
	a_zero: assert property (p_zero) else $error("zero duty not held low"); // RULE_11

	// Up-count trigger match pulses one cycle later
	property p_trig_up;
		pwm_clk_en && count_up && period_count == trig_value[0]
			&& trig_mode[0] == pwm_dt_pkg::TRIG_UP |=> adc_trigger[0] && irq_events.trigger[0];
	endproperty
	a_trig_up: assert property (p_trig_up) else $error("trigger 0 missed"); // RULE_15

	// Asymmetric high goes active only on an up-count match
	property p_asym_up;
		$rose(s_r.hi_lvl[0]) && one_ch && !sym_style && !$past(full_duty[0]) |->
			$past(count_up) && $past(period_count) == $past(duty_hi[0]);
	endproperty
	a_asym_up: assert property (p_asym_up) else $error("asymmetric rise off match"); // RULE_13

	// Symmetric high returns low only on a down-count match
	property p_sym_down;
		$fell(s_r.hi_lvl[0]) && one_ch && sym_style && !$past(zero_duty[0]) |->
			!$past(count_up) && $past(period_count) == $past(duty_hi[0]);
	endproperty
	a_sym_down: assert property (p_sym_down) else $error("symmetric fall off match"); // RULE_12

	// Asymmetric high is cleared only by the low duty counting down
	property p_asym_down;
		$fell(s_r.hi_lvl[0]) && one_ch && !sym_style && !$past(zero_duty[0]) |->
			!$past(count_up) && $past(period_count) == $past(duty_lo[0]);
	endproperty
	a_asym_down: assert property (p_asym_down) else $error("asymmetric fall off match"); // RULE_14

	// Counter at zero while counting up
	sequence s_wrap;
		pwm_clk_en && count_up && period_count == '0;
	endsequence
	// Each period start is offered as an event one cycle later
	property p_period_evt;
		s_wrap |=> irq_events.period_start;
	endproperty
	a_period_evt: assert property (p_period_evt) else $error("period start event missed"); // RULE_16

	// Every raw high-level change raises the match event in the same cycle
	property p_match_evt;
		$changed(s_r.hi_lvl[0]) |-> irq_events.duty_match[0];
	endproperty
	a_match_evt: assert property (p_match_evt) else $error("duty match event missed"); // RULE_16

	// A disabled trigger compare never pulses
	property p_trig_off;
		trig_mode[0] == pwm_dt_pkg::TRIG_OFF |=> !adc_trigger[0] && !irq_events.trigger[0];
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("disabled trigger fired"); // RULE_15

	// Complementary pins never conduct together in one-channel styles
	property p_no_overlap;
		one_ch |-> !(gate_hi[0] && gate_lo[0]);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both gates on"); // RULE_02

	// New active high level while insertion is on
	sequence s_hi_turn_on;
		dt_on[0] && dt_target != '0 && $rose(s_r.hi_lvl[0]);
	endsequence
	property p_mask_start;
		s_hi_turn_on |=> dt_busy[0] && !gate_hi[0] && !gate_lo[0];
	endproperty
	a_mask_start: assert property (p_mask_start) else $error("duty match not masked"); // RULE_05

	// New active low level while insertion is on
	sequence s_lo_turn_on;
		dt_on[0] && dt_target != '0 && $rose(raw_lo[0]);
	endsequence
	property p_lo_mask;
		s_lo_turn_on |=> dt_busy[0] && !gate_lo[0];
	endproperty
	a_lo_mask: assert property (p_lo_mask) else $error("low side not masked"); // RULE_02

	// Normal mode leaves no mask running
	property p_normal_free;
		!motor_mode |=> dt_busy == '0;
	endproperty
	a_normal_free: assert property (p_normal_free) else $error("mask in normal mode"); // RULE_01
endmodule

// ===== src/pwm_dt_pkg.sv
// Shared constants and carrier types for the motor PWM dead-time block
package pwm_dt_pkg;
	// System clock period in nanoseconds (25 MHz)
	localparam int CLK_PERIOD_NS = 40;
	// Channel and trigger counts
	localparam int N_CH = 3;
	localparam int N_TRIG = 6;
	// Period counter width
	localparam int CNT_W = 16;
	// Dead-time length field and counter widths
	localparam int DT_LEN_W = 8;
	localparam int DT_CNT_W = 12;
	// Prescale multipliers as shifts: x4 and x16
	localparam int DT_SHIFT_SLOW = 2;
	localparam int DT_SHIFT_FAST = 4;
	// Motor channel style codes
	localparam logic [1:0] STYLE_TWO_SYM = 2'h0;
	localparam logic [1:0] STYLE_ONE_ASYM = 2'h1;
	localparam logic [1:0] STYLE_ONE_SYM = 2'h2;
	// Trigger compare modes
	localparam logic [1:0] TRIG_OFF = 2'h0;
	localparam logic [1:0] TRIG_UP = 2'h1;
	localparam logic [1:0] TRIG_DOWN = 2'h2;
	localparam logic [1:0] TRIG_BOTH = 2'h3;
	// Output level after reset (inactive)
	localparam logic RST_LEVEL = 1'b0;
	// Dead-time configuration bits
	typedef struct packed {
		logic normal_mode_select;
		logic [1:0] motor_channel_style;
		logic dead_time_enable;
		logic dead_time_prescale_select;
		logic [DT_LEN_W-1:0] dead_time_length;
	} dt_cfg_t;
	// Timing event pulses offered as interrupt requests
	typedef struct packed {
		logic period_start;
		logic [N_CH-1:0] duty_match;
		logic [N_TRIG-1:0] trigger;
	} events_t;
endpackage

// ===== src/dead_time_pair.sv
// Dead-time mask and counter for one high/low output pair
`timescale 1ns/1ns
module dead_time_pair (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pwm_clk_en,
	input wire logic dt_on,
	input wire logic [pwm_dt_pkg::DT_CNT_W-1:0] dt_target,
	input wire logic raw_hi,
	input wire logic raw_lo,
	output logic out_hi,
	output logic out_lo,
	output logic dt_busy
);
	// Whole state of the pair
	typedef struct packed {
		logic prev_hi;
		logic prev_lo;
		logic mask_hi;
		logic mask_lo;
		logic [pwm_dt_pkg::DT_CNT_W-1:0] cnt;
		logic out_hi;
		logic out_lo;
	} pair_state_t;

	pair_state_t s_r; // Registered state
	pair_state_t s_nxt; // Next state
	logic rise_hi; // High side turning active
	logic rise_lo; // Low side turning active

	assign rise_hi = raw_hi & ~s_r.prev_hi;
	assign rise_lo = raw_lo & ~s_r.prev_lo;

	// Mask, count and release
	always_comb begin
		s_nxt = s_r;
		s_nxt.prev_hi = raw_hi;
		s_nxt.prev_lo = raw_lo;
		if (!dt_on) begin
			// No insertion: outputs follow the raw levels
			s_nxt.mask_hi = 1'b0; // RULE_01
			s_nxt.mask_lo = 1'b0;
			s_nxt.cnt = '0;
		end else begin
			// Count prescaled time while masked
			if ((s_r.mask_hi | s_r.mask_lo) && pwm_clk_en) begin
				if (s_r.cnt + 12'h001 >= dt_target) begin
					// Interval over: drop the mask
					s_nxt.mask_hi = 1'b0; // RULE_06
					s_nxt.mask_lo = 1'b0;
					s_nxt.cnt = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + 12'h001;
				end
			end
			// New active edge masks and restarts the count
			if (rise_hi && dt_target != '0) begin
				s_nxt.mask_hi = 1'b1; // RULE_02 RULE_05
				s_nxt.mask_lo = 1'b0;
				s_nxt.cnt = '0; // RULE_19
			end
			if (rise_lo && dt_target != '0) begin
				s_nxt.mask_lo = 1'b1; // RULE_02 RULE_05
				s_nxt.mask_hi = 1'b0;
				s_nxt.cnt = '0; // RULE_19
			end
		end
		// A pulse shorter than the mask never reaches the pin
		s_nxt.out_hi = raw_hi & ~s_nxt.mask_hi; // RULE_08
		s_nxt.out_lo = raw_lo & ~s_nxt.mask_lo; // RULE_09
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign out_hi = s_r.out_hi;
	assign out_lo = s_r.out_lo;
	assign dt_busy = s_r.mask_hi | s_r.mask_lo;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Active edge is held off for at least one cycle
	property p_rise_masked;
		dt_on && rise_hi && dt_target != '0 |=> !out_hi;
	endproperty
	a_rise_masked: assert property (p_rise_masked) else $error("high side not masked at edge"); // RULE_05

	// Count restarts on every new edge
	property p_restart;
		dt_on && (rise_hi || rise_lo) && dt_target != '0 |=> s_r.cnt == '0 && dt_busy;
	endproperty
	a_restart: assert property (p_restart) else $error("dead-time count not restarted"); // RULE_19

	// Count never reaches the target while masked
	property p_bound;
		dt_busy |-> s_r.cnt < dt_target;
	endproperty
	a_bound: assert property (p_bound) else $error("dead-time count overran"); // RULE_06

	// Without insertion the pins follow the raw levels
	property p_no_dt;
		!dt_on |=> out_hi == $past(raw_hi) && out_lo == $past(raw_lo);
	endproperty
	a_no_dt: assert property (p_no_dt) else $error("output differs with dead-time off"); // RULE_01
endmodule

// ===== test/gate_bridge_model.sv
// Behavioural inverter bridge and ADC start input facing the gate outputs
`timescale 1ns/1ns
module gate_bridge_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [pwm_dt_pkg::N_CH-1:0] gate_hi,
	input wire logic [pwm_dt_pkg::N_CH-1:0] gate_lo,
	input wire logic [pwm_dt_pkg::N_TRIG-1:0] adc_trigger,
	output int shoot_cnt,
	output int adc_starts
);
	// Leg cycles with both switches on
	int shoot_q = 0;
	// Conversions started by trigger pulses
	int start_q = 0;
	assign shoot_cnt = shoot_q;
	assign adc_starts = start_q;
	// A leg shorts when both switches conduct; each pulse starts one conversion
	always @(posedge clk_sys) begin
		if (!rst) begin
			shoot_q <= shoot_q + $countones(gate_hi & gate_lo);
			start_q <= start_q + $countones(adc_trigger);
		end
	end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for dead-time insertion, compare timing and trigger events
`timescale 1ns/1ns
module tb_top;
	// Half period of the triangle count
	localparam int PER = 100;
	logic clk_sys, rst, pwm_clk_en, count_up, watch, hi_prev, b_prev;
	logic [15:0] period_count;
	logic [2:0][15:0] duty_hi, duty_lo;
	pwm_dt_pkg::dt_cfg_t dt_cfg;
	logic [5:0][15:0] trig_value;
	logic [5:0][1:0] trig_mode;
	logic [2:0] gate_hi, gate_lo, dt_busy;
	logic [5:0] adc_trigger;
	pwm_dt_pkg::events_t irq_events;
	logic [6:0] exp_ev;
	int shoot_cnt, adc_starts, failures, num_checks, ch, hcnt, bcnt, hon, lon, n_trig, chk_hi, chk_b, n_dm;
	// Expected event vectors, pulse widths and busy widths
	logic [6:0] q_ev[$];
	int q_hi[$];
	int q_b[$];
	// Columns: normal, style, dead time, x16, length, duty hi, duty lo, hi width, busy width,
	// busy per period, hi cycles, lo cycles; -1 leaves a measurement out
	int rows[10][12] = '{
		'{0, 2, 0, 0, 0, 30, 30, 140, 0, 0, 280, 120},
		'{0, 1, 0, 0, 0, 30, 50, 120, 0, 0, 240, 160},
		'{0, 2, 1, 0, 3, 30, 30, -1, 12, 2, -1, -1},
		'{0, 1, 1, 1, 2, 30, 50, -1, 32, 2, -1, -1},
		'{0, 2, 1, 1, 3, 90, 90, 0, 68, 1, 0, -1},
		'{0, 2, 1, 1, 3, 10, 10, -1, -1, 0, -1, 0},
		'{0, 2, 1, 0, 3, 100, 100, 0, 0, 0, 400, 0},
		'{0, 2, 1, 0, 3, 0, 0, 0, 0, 0, 0, 400},
		'{0, 0, 1, 0, 3, 30, 105, 140, 0, 0, 280, 0},
		'{1, 0, 1, 0, 3, 105, 0, 0, 0, 0, 400, 0}
	};
	pwm_dead_time_insertion #(.CW(16)) u_pwm_dead_time_insertion (.clk_sys(clk_sys), .rst(rst),
		.pwm_clk_en(pwm_clk_en), .period_count(period_count), .count_up(count_up),
		.period_value(16'(PER)), .duty_hi(duty_hi), .duty_lo(duty_lo), .dt_cfg(dt_cfg),
		.trig_value(trig_value), .trig_mode(trig_mode), .gate_hi(gate_hi), .gate_lo(gate_lo),
		.dt_busy(dt_busy), .adc_trigger(adc_trigger), .irq_events(irq_events));
	gate_bridge_model u_gate_bridge_model (.clk_sys(clk_sys), .rst(rst), .gate_hi(gate_hi),
		.gate_lo(gate_lo), .adc_trigger(adc_trigger), .shoot_cnt(shoot_cnt), .adc_starts(adc_starts));
	// Compare one value and count it
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One configuration: reset, one priming period, two watched periods
	task automatic run_row(input int r);
		int p, k, c, t;
		logic up;
		logic [6:0] ev;
		@(posedge clk_sys);
		rst <= 1'b1;
		pwm_clk_en <= 1'b0;
		ch = $urandom % 3;
		dt_cfg.normal_mode_select <= 1'(rows[r][0]);
		dt_cfg.motor_channel_style <= 2'(rows[r][1]);
		dt_cfg.dead_time_enable <= 1'(rows[r][2]);
		dt_cfg.dead_time_prescale_select <= 1'(rows[r][3]);
		dt_cfg.dead_time_length <= 8'(rows[r][4]);
		duty_hi <= {3{16'(rows[r][5])}};
		duty_lo <= {3{16'(rows[r][6])}};
		for (t = 0; t < 6; t++) begin
			trig_mode[t] <= 2'((t + r) % 4);
			trig_value[t] <= 16'(1 + $urandom % (PER - 1));
		end
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		hcnt = 0;
		bcnt = 0;
		hon = 0;
		lon = 0;
		n_dm = 0;
		chk_hi = rows[r][7] >= 0;
		chk_b = rows[r][8] >= 0;
		if (rows[r][7] > 0) repeat (2) q_hi.push_back(rows[r][7]);
		repeat (2 * rows[r][9]) q_b.push_back(rows[r][8]);
		// Triangle count: up 0..PER-1, down PER..1
		for (p = 0; p < 3; p++)
			for (k = 0; k < 2 * PER; k++) begin
				@(posedge clk_sys);
				up = k < PER;
				c = up ? k : 2 * PER - k;
				period_count <= 16'(c);
				count_up <= up;
				pwm_clk_en <= 1'b1;
				watch <= p != 0;
				ev = {up && c == 0, 6'h00};
				for (t = 0; t < 6; t++)
					if (trig_value[t] == 16'(c) && (trig_mode[t] == pwm_dt_pkg::TRIG_BOTH
						|| (trig_mode[t] == pwm_dt_pkg::TRIG_UP && up) || (trig_mode[t] == pwm_dt_pkg::TRIG_DOWN && !up)))
						ev[t] = 1'b1;
				if (ev !== 7'h00) begin
					q_ev.push_back(ev);
					n_trig += $countones(ev[5:0]);
				end
			end
		@(posedge clk_sys);
		watch <= 1'b0;
		pwm_clk_en <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("hi_left", q_hi.size(), 0);
		check("busy_left", q_b.size(), 0);
		check("event_left", q_ev.size(), 0);
		if (rows[r][10] >= 0) check("hi_cycles", hon, rows[r][10]);
		if (rows[r][11] >= 0) check("lo_cycles", lon, rows[r][11]);
		// High duty, and low duty in normal and two-channel modes, strictly inside the period change their level twice a period
		check("match_events", n_dm, 4 * int'(rows[r][5] > 0 && rows[r][5] < PER)
			+ 4 * int'((rows[r][0] || rows[r][1] == 0) && rows[r][6] > 0 && rows[r][6] < PER));
		q_hi.delete();
		q_b.delete();
		q_ev.delete();
	endtask
	// Clock source
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Result watcher: takes the oldest note whenever a result appears
	always @(posedge clk_sys) begin
		if (!rst && {irq_events.period_start, adc_trigger} !== 7'h00) begin
			exp_ev = q_ev.size() ? q_ev.pop_front() : 7'h00;
			check("events", {irq_events.period_start, adc_trigger, irq_events.trigger},
				{exp_ev, exp_ev[5:0]});
		end
		if (watch && chk_hi && hi_prev && gate_hi[ch] === 1'b0) begin
			check("hi_width", hcnt, q_hi.size() ? q_hi.pop_front() : -1);
			hcnt = 0;
		end
		if (watch && chk_b && b_prev && dt_busy[ch] === 1'b0) begin
			check("busy_width", bcnt, q_b.size() ? q_b.pop_front() : -1);
			bcnt = 0;
		end
		if (watch && dt_busy[ch] === 1'b1) check("masked", {gate_hi[ch], gate_lo[ch]}, 0);
		if (watch && gate_hi[ch] === 1'b1) hcnt++;
		if (watch && gate_hi[ch] === 1'b1) hon++;
		if (watch && gate_lo[ch] === 1'b1) lon++;
		if (watch && irq_events.duty_match[ch] === 1'b1) n_dm++;
		if (watch && dt_busy[ch] === 1'b1) bcnt++;
		hi_prev = gate_hi[ch] === 1'b1;
		b_prev = dt_busy[ch] === 1'b1;
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		pwm_clk_en = 1'b0;
		count_up = 1'b0;
		watch = 1'b0;
		period_count = 16'h0000;
		duty_hi = '0;
		duty_lo = '0;
		dt_cfg = '0;
		trig_value = '0;
		trig_mode = '0;
		ch = 0;
		void'($urandom(32'hffce));
		repeat (2) @(posedge clk_sys);
		for (int r = 0; r < 10; r++) run_row(r);
		check("bridge_short", shoot_cnt, 0);
		check("adc_starts", adc_starts, n_trig);
		report_and_stop();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		report_and_stop();
	end
endmodule
